// *** tone_burst_pkg.sv ***
// Purpose: Shared constants for the sine tone-burst generator.
// Assumes: Samples are signed 16 bit, gains are unsigned Q1.15 fractions of full scale.
// Notes:   Cycle counts are 17 bits so that a repeat period of 65,536 fits.
package tone_burst_pkg;
  localparam int unsigned SAMPLE_W      = 16;         // Width of a signed sample.
  localparam int unsigned GAIN_W        = 16;         // Width of a Q1.15 gain.
  localparam int unsigned RATIO_W       = 16;         // Width of a Q0.16 OFF ratio.
  localparam int unsigned COUNT_W       = 17;         // Width of cycle counts.
  localparam int unsigned PROD_W        = 32;         // Width of a full product.
  localparam int unsigned GAIN_FRAC     = 15;         // Fraction bits of a gain.
  localparam int unsigned RATIO_FRAC    = 16;         // Fraction bits of a ratio.
  localparam logic [16:0] ON_MIN        = 17'h00001;  // Shortest burst, 1 cycle.
  localparam logic [16:0] ON_MAX        = 17'h0ffff;  // Longest burst, 65,535 cycles.
  localparam logic [16:0] PERIOD_MIN    = 17'h00002;  // Shortest period, 2 cycles.
  localparam logic [16:0] PERIOD_MAX    = 17'h10000;  // Longest period, 65,536 cycles.
  localparam logic [16:0] ON_RESET      = 17'h00001;  // Burst length after reset.
  localparam logic [16:0] PERIOD_RESET  = 17'h00003;  // Period after reset.
  localparam logic [16:0] COUNT_RESET   = 17'h00000;  // Cycle count after reset.
  localparam logic [15:0] RATIO_RESET   = 16'h4000;   // OFF ratio after reset, one quarter.
  localparam logic [15:0] RATIO_UNITY   = 16'hffff;   // Ratio code read as exactly one.
  localparam logic [15:0] GAIN_RESET    = 16'h0000;   // Gain after reset.
  localparam logic [15:0] SAMPLE_RESET  = 16'h0000;   // Sample after reset.
  localparam int unsigned COARSE_SHIFT  = 8;          // Ratios below 2^-8 keep fewer bits.
  localparam logic [15:0] COARSE_LIMIT  = 16'h0100;   // Threshold of the coarse range.
  localparam logic [15:0] COARSE_MASK   = 16'hfff0;   // Bits kept in the coarse range.
  localparam logic [15:0] FINE_MASK     = 16'hffff;   // Bits kept in the fine range.
  localparam int unsigned BUF_DEPTH     = 2;          // Entries in the output buffer.
endpackage

// *** sine_tone_burst_gen.sv ***
// Purpose: Keys an incoming sine stream between an ON gain and a reduced OFF gain.
// Assumes: The sine source marks each positive-going zero crossing with in_wrap on
//          the first sample after the crossing, and settings are held steady by software.
// Notes:   A two-entry buffer sits before the output so that a receiver stall loses no sample.
//          The cycle count is kept across loads; a count past a new period restarts on the next wrap.
//          The sine source itself lies outside; only its samples and wrap marker come in.
//          Amplitude is unsigned Q1.15 and the OFF ratio unsigned Q0.16, so neither carries a sign.
//          A load is best made between streams, as the new lengths act from the next wrap on.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Burst length accepted from 1 to 65,535.
// - Period accepted from 2 to 65,536 cycles.
// - Burst not shorter than period is rejected.
// - Period counts from burst start to start.
// - ON phase uses the main amplitude.
// - OFF phase scales ON amplitude by ratio.
// - Unity ratio gives a continuous sinewave.
// - Ratios below 2^-8 quantized coarser, effective value reported.
// - Keying changes only at positive zero crossings.
// - Lengths are whole cycle counts only.
module sine_tone_burst_gen (
  // Clock and reset.
  input  wire logic                                  clk,
  input  wire logic                                  arst_n,
  // Settings from control software.
  input  wire logic [tone_burst_pkg::GAIN_W-1:0]     amplitude,
  input  wire logic [tone_burst_pkg::COUNT_W-1:0]    burst_on,
  input  wire logic [tone_burst_pkg::COUNT_W-1:0]    interval,
  input  wire logic [tone_burst_pkg::RATIO_W-1:0]    low_level,
  input  wire logic                                  settings_load,
  // Status back to control software.
  output logic      [tone_burst_pkg::RATIO_W-1:0]    low_level_actual,
  output logic      [tone_burst_pkg::COUNT_W-1:0]    burst_on_actual,
  output logic      [tone_burst_pkg::COUNT_W-1:0]    interval_actual,
  output logic                                       settings_reject,
  output logic                                       burst_active,
  // Sine stream from the phase accumulator.
  input  wire logic [tone_burst_pkg::SAMPLE_W-1:0]   in_sample,
  input  wire logic                                  in_wrap,
  input  wire logic                                  in_valid,
  output logic                                       in_ready,
  // Sample stream to the device under test.
  output logic      [tone_burst_pkg::SAMPLE_W-1:0]   out_sample,
  output logic                                       out_valid,
  input  wire logic                                  out_ready
);
  import tone_burst_pkg::*;

  // The whole state of the block.
  // One struct gives a single reset point and a single register process.
  typedef struct packed {
    logic [COUNT_W-1:0]  on_len;      // Accepted burst length in cycles.
    logic [COUNT_W-1:0]  period;      // Accepted period in cycles.
    logic [RATIO_W-1:0]  ratio;       // Quantized OFF ratio.
    logic                reject;      // Last load was refused.
    logic [COUNT_W-1:0]  count;       // Cycles since the current burst began.
    logic                on_phase;    // Gain selected for the current cycle.
    logic [SAMPLE_W-1:0] buf0;        // Buffer entry at the head.
    logic [SAMPLE_W-1:0] buf1;        // Buffer entry behind the head.
    logic [1:0]          fill;        // Entries held in the buffer.
  } state_s;

  state_s state;       // Registered state.
  state_s next_state;  // Value for the next edge.

  // Keep fewer ratio bits at heavy attenuation, as the steps there are coarser.
  // The fine range passes every bit through unchanged.
  function automatic logic [RATIO_W-1:0] quantize(input logic [RATIO_W-1:0] r);
    if (r < COARSE_LIMIT) begin
      return r & COARSE_MASK;
    end
    return r & FINE_MASK;
  endfunction

  // Signed sample times unsigned gain with the given number of fraction bits.
  // The product is truncated, not rounded, which keeps the path short at a half-step cost.
  function automatic logic [SAMPLE_W-1:0] scale(input logic [SAMPLE_W-1:0] s,
                                                input logic [GAIN_W-1:0] g,
                                                input int unsigned frac);
    logic signed [PROD_W:0] p;
    p = $signed({{(PROD_W-SAMPLE_W+1){s[SAMPLE_W-1]}}, s}) * $signed({17'h00000, g});
    return SAMPLE_W'(p >>> frac);
  endfunction

  // Combinational terms; take and give come from the assigns below, the rest from the one always_comb.
  logic [GAIN_W-1:0]   off_gain;   // Amplitude scaled by the OFF ratio.
  logic [GAIN_W-1:0]   gain;       // Gain applied to the present sample.
  logic [SAMPLE_W-1:0] scaled;     // Present sample after gain.
  logic                take;       // An input sample is accepted this cycle.
  logic                give;       // An output sample leaves this cycle.
  logic                cur_on;     // ON phase for the sample being taken.
  logic [COUNT_W-1:0]  count_inc;  // Cycle count after a wrap.
  logic                load_ok;    // Offered settings are legal.
  logic [PROD_W-1:0]   off_prod;   // Unsigned amplitude times OFF ratio.

  // Handshake terms; the input stalls once both entries are full.
  // in_ready is decoded from the fill alone, so a full buffer takes no sample on the edge at which it drains.
  assign in_ready = (state.fill != 2'(BUF_DEPTH));
  assign take     = in_valid & in_ready;
  assign give     = out_valid & out_ready;

  // Fill a copy of the state from the present state and the inputs.
  // Defaults hold every field, so only the fields that change are written below.
  always_comb begin
    next_state = state;
    // Settings are checked for range and for some OFF time in each period.
    load_ok = (burst_on >= ON_MIN) && (burst_on <= ON_MAX)
           && (interval >= PERIOD_MIN) && (interval <= PERIOD_MAX)
           && (burst_on < interval);
    if (settings_load) begin
      next_state.reject = !load_ok;
      // A refused load still takes the ratio, which has no illegal value.
      next_state.ratio  = quantize(low_level);
      // Only a legal pair replaces the lengths, so the running burst keeps its shape.
      if (load_ok) begin
        next_state.on_len = burst_on;
        next_state.period = interval;
      end
    end
    // A wrap marks a new whole cycle; the count restarts at the period.
    // A count left above a newly shortened period also restarts on the next wrap.
    count_inc = state.count + 17'h00001;
    cur_on    = state.on_phase;
    if (take && in_wrap) begin
      // The period runs from one burst start to the next, not from a burst end.
      if (count_inc >= state.period) begin
        next_state.count = COUNT_RESET;
      end else begin
        // Still inside the period: one more whole cycle.
        next_state.count = count_inc;
      end
      // The sample that carries the wrap already belongs to the new cycle.
      cur_on = (next_state.count < state.on_len);
      next_state.on_phase = cur_on;
    end
    // Gain chosen from the phase; a unity ratio keeps the ON level unchanged.
    // The OFF product is unsigned, as a gain of one or more is a magnitude, not a sign.
    off_prod = PROD_W'(amplitude) * PROD_W'(state.ratio);
    off_gain = (state.ratio == RATIO_UNITY) ? amplitude : off_prod[PROD_W-1:RATIO_FRAC];
    // The ON level is the amplitude itself; nothing scales it.
    gain     = cur_on ? amplitude : off_gain;
    scaled   = scale(in_sample, gain, GAIN_FRAC);
    // Two-entry buffer; the head leaves first.
    case ({take, give})
      2'b10: begin
        // Take only: the new sample goes behind whatever is held.
        if (state.fill == 2'd0) begin
          next_state.buf0 = scaled;
        end else begin
          next_state.buf1 = scaled;
        end
        next_state.fill = state.fill + 2'd1;
      end
      2'b01: begin
        // Give only: the second entry moves up to the head.
        next_state.buf0 = state.buf1;
        next_state.fill = state.fill - 2'd1;
      end
      2'b11: begin
        // Take and give: the fill stays and the queue moves up by one.
        if (state.fill == 2'd1) begin
          next_state.buf0 = scaled;
        end else begin
          next_state.buf0 = state.buf1;
          next_state.buf1 = scaled;
        end
      end
      default: begin
        // Neither side moves, so everything holds.
        next_state.fill = state.fill;
      end
    endcase
  end

  // Register the state; reset values are constants.
  // After reset the count is zero and the phase ON, so samples before the first wrap stay ON.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '{on_len: ON_RESET, period: PERIOD_RESET, ratio: RATIO_RESET, reject: 1'b0,
                 count: COUNT_RESET, on_phase: 1'b1, buf0: SAMPLE_RESET, buf1: SAMPLE_RESET,
                 fill: 2'd0};
    end else begin
      // Between resets every field follows the copy.
      state <= next_state;
    end
  end

  // Outputs straight from state flip-flops.
  // The receiver sees only registered values; no gain arithmetic reaches the pins.
  assign out_sample       = state.buf0;
  assign out_valid        = (state.fill != 2'd0);
  assign low_level_actual = state.ratio;
  assign burst_on_actual  = state.on_len;
  assign interval_actual  = state.period;
  assign settings_reject  = state.reject;
  assign burst_active     = state.on_phase;

  // Checks below watch only what this block drives.
  // A load may shorten the period below a running count, so count checks are tied to wraps.
  // A load and a wrap in one cycle use the old lengths for that wrap.
  // Buffer checks guard the promise that a receiver stall loses no sample.

  // After a wrap the count is below the period that was in force at that wrap.
  count_range_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && in_wrap) |=> state.count < $past(state.period))
    else $error("Cycle count reached the period.");

  // Accepted settings always leave OFF time in the period.
  on_shorter_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.on_len < state.period)
    else $error("Burst length not below period.");

  // Burst length stays in range.
  on_range_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.on_len >= ON_MIN && state.on_len <= ON_MAX)
    else $error("Burst length out of range.");

  // Period stays in range.
  period_range_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.period >= PERIOD_MIN && state.period <= PERIOD_MAX)
    else $error("Period out of range.");

  // Phase changes only on an accepted wrap.
  phase_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(take && in_wrap) |=> $stable(state.on_phase))
    else $error("Phase changed away from a crossing.");

  // Phase follows the count after each wrap without a load.
  phase_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && in_wrap && !settings_load) |=> state.on_phase == (state.count < state.on_len))
    else $error("Phase disagrees with count.");

  // ON phase uses the main amplitude.
  on_gain_a: assert property (@(posedge clk) disable iff (!arst_n)
    cur_on |-> gain == amplitude)
    else $error("ON gain is not the amplitude.");

  // A unity ratio gives the ON level in the OFF phase too.
  unity_gain_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.ratio == RATIO_UNITY |-> gain == amplitude)
    else $error("Unity ratio changed the level.");

  // An illegal load leaves the lengths untouched and raises reject.
  reject_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    (settings_load && !load_ok) |=> state.reject && $stable(state.on_len) && $stable(state.period))
    else $error("Illegal settings were taken.");

  // The reported ratio is the quantized one.
  ratio_report_a: assert property (@(posedge clk) disable iff (!arst_n)
    settings_load |=> low_level_actual == quantize($past(low_level)))
    else $error("Reported ratio is not quantized.");

  // The OFF level never exceeds the ON level.
  off_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    !cur_on |-> gain <= amplitude)
    else $error("OFF gain above the amplitude.");

  // A legal load takes both lengths and clears reject.
  reject_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    (settings_load && load_ok) |=> !state.reject && state.on_len == $past(burst_on) && state.period == $past(interval))
    else $error("Legal settings were not taken.");

  // Small ratios keep only the coarse bits.
  ratio_coarse_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.ratio < COARSE_LIMIT |-> (state.ratio & ~COARSE_MASK) == 16'h0000)
    else $error("Small ratio keeps fine bits.");

  // A wrap at the end of the period starts a new burst.
  count_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && in_wrap && count_inc >= state.period) |=> state.count == COUNT_RESET)
    else $error("Count did not restart at the period.");

  // The count moves only on whole cycles.
  count_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(take && in_wrap) |=> $stable(state.count))
    else $error("Count moved without a wrap.");

  // The ratio changes only on a load.
  ratio_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !settings_load |=> $stable(state.ratio))
    else $error("Ratio changed without a load.");

  // The lengths change only on a load.
  length_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !settings_load |=> $stable(state.on_len) && $stable(state.period))
    else $error("Lengths changed without a load.");

  // A stalled head sample stays on the output.
  out_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (out_valid && !out_ready) |=> out_valid && $stable(out_sample))
    else $error("Stalled output sample changed.");

  // The buffer never holds more than two entries.
  fill_range_a: assert property (@(posedge clk) disable iff (!arst_n)
    state.fill <= 2'd2)
    else $error("Buffer overfilled.");

  // A taken sample with nothing leaving adds one entry.
  stall_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    (take && !give) |=> state.fill == $past(state.fill) + 2'd1)
    else $error("Taken sample was lost.");

endmodule
`default_nettype wire

// *** sample_sink.sv ***
// Purpose: Receiver model for the keyed sample stream, able to stall.
// Assumes: Mode 0 is always ready, mode 1 is ready one cycle in three, mode 2 never.
// Notes:   Ready moves only just after a rising edge, as a real receiver would.
`timescale 1ns/1ns
`default_nettype none
module sample_sink (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Stall pattern chosen by the bench.
  input  wire logic [1:0] mode,
  // Handshake towards the generator.
  output logic            out_ready
);
  logic [1:0] phase; // Position in the three-cycle pattern.

  // A slow receiver makes both buffer entries fill, which is the hazard worth probing.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase     <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      phase     <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      out_ready <= (mode == 2'h0) || (mode == 2'h1 && phase == 2'h0);
    end
  end
endmodule
`default_nettype wire

// *** test_sine_tone_burst_gen.sv ***
// Purpose: Self-checking bench for the tone-burst generator.
// Assumes: Expected samples come from a cycle-count model kept in the bench.
// Notes:   The cycle count survives loads, so the model never resets it on a load either.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module test_sine_tone_burst_gen;
  import tone_burst_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, load = 1'b0, in_wrap = 1'b0, in_valid = 1'b0;
  logic [15:0] amp = 16'h6000, ratio = 16'h0000, in_sample = 16'h0000, out_sample, ratio_q;
  logic [16:0] on_len = 17'h00000, per = 17'h00000, on_q, per_q, on_m, per_m, cnt_m;
  logic [15:0] ratio_m, exp_s;
  logic        reject, active, in_ready, out_valid, out_ready, act_m, rej_m;
  logic [1:0]  mode = 2'h0;
  logic [15:0] wave [4] = '{16'h0000, 16'h5a82, 16'h7fff, 16'ha57e}; // One sine cycle.
  logic [50:0] cases [8] = '{{17'd2, 17'd4, 16'h4000, 1'b1}, {17'd4, 17'd4, 16'h2000, 1'b0},
    {17'd0, 17'd4, 16'h8000, 1'b0}, {17'd3, 17'd1, 16'h4000, 1'b0}, {17'd1, 17'h10001, 16'h4000, 1'b0},
    {17'h0ffff, 17'h10000, 16'h00ff, 1'b1}, {17'd1, 17'd2, 16'hffff, 1'b1}, {17'd5, 17'd3, 16'h0123, 1'b0}};
  int n_errors = 0, checks_done = 0;
  longint prod;
  logic [15:0] exp_q [$];

  // Clock at 25 MHz.
  always #20 clk = ~clk;

  sine_tone_burst_gen uut (.clk(clk), .arst_n(arst_n), .amplitude(amp), .burst_on(on_len), .interval(per),
    .low_level(ratio), .settings_load(load), .low_level_actual(ratio_q), .burst_on_actual(on_q),
    .interval_actual(per_q), .settings_reject(reject), .burst_active(active), .in_sample(in_sample),
    .in_wrap(in_wrap), .in_valid(in_valid), .in_ready(in_ready), .out_sample(out_sample),
    .out_valid(out_valid), .out_ready(out_ready));
  sample_sink sink (.clk(clk), .arst_n(arst_n), .mode(mode), .out_ready(out_ready));

  // Every sample the receiver takes must match the oldest expected one.
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      exp_s = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      `CHK("out_sample", exp_s, out_sample)
    end
  end

  // Offer one sample, wait until taken, and predict its keyed value.
  task automatic send(input logic [15:0] s, input logic w);
    logic [15:0] g;
    logic [31:0] t;
    int n;
    n = 0;
    in_sample <= s;
    in_wrap   <= w;
    in_valid  <= 1'b1;
    @(posedge clk);
    while (in_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    if (n >= 100) `CHK("in_ready", 1'b1, in_ready)
    if (w) begin
      cnt_m = (cnt_m + 18'h1 >= {1'b0, per_m}) ? 17'h0 : cnt_m + 17'h1;
      act_m = cnt_m < on_m;
    end
    t = amp * ratio_m;
    g = act_m ? amp : ((ratio_m == RATIO_UNITY) ? amp : t[31:16]);
    prod = longint'($signed(s)) * longint'({1'b0, g});
    prod = prod >>> 15;
    exp_q.push_back(prod[15:0]);
  endtask

  // Whole sine cycles, then let the buffer drain.
  task automatic stream(input int cycles);
    int n;
    for (int c = 0; c < cycles; c++) begin
      for (int k = 0; k < 4; k++) send(wave[k], k == 0);
    end
    in_valid <= 1'b0;
    n = 0;
    while ((out_valid !== 1'b0 || exp_q.size() > 0) && n < 100) begin
      n++;
      @(posedge clk);
    end
    `CHK("drained", 1'b1, exp_q.size() == 0)
    `CHK("burst_active", act_m, active)
  endtask

  // Pulse a load, update the model and compare the reported settings.
  task automatic load_set(input logic [50:0] c);
    {on_len, per, ratio} <= c[50:1];
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    @(posedge clk);
    rej_m   = !c[0];
    ratio_m = (c[16:1] < COARSE_LIMIT) ? (c[16:1] & COARSE_MASK) : c[16:1];
    if (c[0]) {on_m, per_m} = c[50:17];
    `CHK("settings_reject", rej_m, reject)
    `CHK("burst_on_actual", on_m, on_q)
    `CHK("interval_actual", per_m, per_q)
    `CHK("low_level_actual", ratio_m, ratio_q)
  endtask

  task automatic wrap_up;
    $display("errors %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run of under a thousand cycles.
  initial begin
    #800000;
    n_errors++;
    wrap_up();
  end

  // Reset, then defaults, then each settings case followed by keyed traffic.
  initial begin
    {on_m, per_m, ratio_m, cnt_m, act_m} = {ON_RESET, PERIOD_RESET, RATIO_RESET, COUNT_RESET, 1'b1};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    `CHK("reset on", ON_RESET, on_q)
    `CHK("reset period", PERIOD_RESET, per_q)
    `CHK("reset flags", 4'b0101, {reject, active, out_valid, in_ready})
    mode <= 2'h1;
    stream(7);
    for (int i = 0; i < 8; i++) begin
      load_set(cases[i]);
      mode <= i[1:0] % 2'h2;
      stream(6);
    end
    mode <= 2'h2;
    send(wave[1], 1'b0);
    send(wave[2], 1'b0);
    in_valid <= 1'b0;
    @(posedge clk);
    `CHK("in_ready full", 1'b0, in_ready)
    mode <= 2'h0;
    stream(1);
    // A second reset in mid-run must restore settings, flags and phase.
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    {on_m, per_m, ratio_m, cnt_m, act_m} = {ON_RESET, PERIOD_RESET, RATIO_RESET, COUNT_RESET, 1'b1};
    @(posedge clk);
    `CHK("reset again on", ON_RESET, on_q)
    `CHK("reset again period", PERIOD_RESET, per_q)
    `CHK("reset again ratio", RATIO_RESET, ratio_q)
    `CHK("reset again flags", 4'b0101, {reject, active, out_valid, in_ready})
    stream(2);
    wrap_up();
  end
endmodule
`default_nettype wire
